// *** src/tcp_timer0_cmp_portb.sv ***
// Notes on behaviour
// - Each register answers at its data-space offset, and at that offset less 0x20 for I/O-space access.
// - Port B direction is eight read/write bits, all zero after reset.
// - Writing one to a bit of the pin register inverts that pin's output state.
// - A nonzero channel A output mode puts the compare output on the pin instead of the port value.
// - The pin driver is enabled only by its direction bit, even while the compare output owns it.
// - Outside PWM, codes 00/01/10/11 mean disconnect, toggle, clear and set on match.
// - In fast PWM, code 01 holds the compare output on the pin unless waveform bit 2 is set, when it toggles on match.
// - In fast PWM, code 10 clears on match and sets at bottom.
// - In fast PWM, code 11 sets on match and clears at bottom.
// - Control A holds both output mode fields in bits 7:4 and waveform bits 1:0, reset zero.
// - Control B takes force strobes at 7 and 6 without storing them, and holds waveform bit 2 at 3 and clock select at 2:0.
// - The channel A force strobe outside PWM applies the output action at once, without interrupt or clear; bit 6 has no effect.
// - The clock select chooses what advances the counter.

`include "tcp_defs.svh"
`default_nettype none

module tcp_timer0_cmp_portb #(
  parameter int PIN_W = 8,
  parameter int CMP_PIN = 6
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // CPU register access
  input wire logic [7:0] i_addr,
  input wire logic i_io_space,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wr_data,
  output logic [7:0] o_rd_data,
  // Compare value and external count clock
  input wire logic [7:0] i_cmp_a,
  input wire logic i_ext_clk,
  // Port B pins
  input wire logic [PIN_W-1:0] i_pin_b,
  output logic [PIN_W-1:0] o_pin_b,
  output logic [PIN_W-1:0] o_pin_b_oe,
  // Counter status
  output logic [7:0] o_count,
  output logic o_match_a
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // Registers are byte wide, so the port must be too.
  if (PIN_W != 8 || CMP_PIN < 0 || CMP_PIN >= PIN_W) begin : g_bad_param
    $error("Port must be 8 pins wide with the compare pin inside it.");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  logic [7:0] dir_q;
  logic [7:0] port_q;
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [9:0] pre_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_top;
  logic [7:0] data_addr;
  logic [2:0] wgm;
  logic [2:0] cs;
  logic tick;
  logic match_a;
  logic bottom;
  logic wr_pin;
  logic wr_dir;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic override;
  logic [PIN_W-1:0] pin_out_d;
  logic [PIN_W-1:0] pin_out_q;
  logic match_q;
  logic [7:0] rd_d;

  tcp_wave_if wif ();

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= i_pin_b;
      pin_s2_q <= pin_s1_q;
    end
  end

  // The third stage only serves the edge detector.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= i_ext_clk;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // I/O-space addresses are shifted into the data space once, so one
  // decoder serves both kinds of access.
  assign data_addr = i_io_space ? ((i_addr & `TCP_IO_ADDR_MASK) + `TCP_IO_BASE)
                                : i_addr;

  always_comb begin
    wr_pin = 1'b0;
    wr_dir = 1'b0;
    wr_ctrl_a = 1'b0;
    wr_ctrl_b = 1'b0;
    if (!i_wr) begin
      wr_pin = 1'b0;
    end else if (data_addr == `TCP_OFS_PIN_B) begin
      wr_pin = 1'b1;
    end else if (data_addr == `TCP_OFS_DIR_B) begin
      wr_dir = 1'b1;
    end else if (data_addr == `TCP_OFS_CTRL_A) begin
      wr_ctrl_a = 1'b1;
    end else if (data_addr == `TCP_OFS_CTRL_B) begin
      wr_ctrl_b = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Port B registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dir_q <= `TCP_RST_DIR_B;
    end else if (wr_dir) begin
      dir_q <= i_wr_data;
    end
  end

  // The output latch has no write path of its own here; a pin write
  // is the only way software changes it.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      port_q <= `TCP_RST_PORT_B;
    end else if (wr_pin) begin
      port_q <= port_q ^ i_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Timer control registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_a_q <= `TCP_RST_CTRL_A;
    end else if (wr_ctrl_a) begin
      ctrl_a_q <= i_wr_data & `TCP_CTRL_A_MASK;
    end
  end

  // Force strobes are not stored, so they always read as zero.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_b_q <= `TCP_RST_CTRL_B;
    end else if (wr_ctrl_b) begin
      ctrl_b_q <= i_wr_data & `TCP_CTRL_B_MASK;
    end
  end

  assign wgm = {ctrl_b_q[`TCP_WGM_2], ctrl_a_q[`TCP_WGM_HI:`TCP_WGM_LO]};
  assign cs = ctrl_b_q[`TCP_CS_HI:`TCP_CS_LO];

  // ----------------------------------------------------------------
  // Prescaler and clock select
  // ----------------------------------------------------------------
  // The prescaler free-runs; a divided tick can land up to one full
  // divide period after the select is written.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 10'h001;
    end
  end

  always_comb begin
    case (cs)
      `TCP_CS_STOP: tick = 1'b0;
      `TCP_CS_DIV1: tick = 1'b1;
      `TCP_CS_DIV8: tick = (pre_q & `TCP_PRE_MASK_8) == `TCP_PRE_MASK_8;
      `TCP_CS_DIV64: tick = (pre_q & `TCP_PRE_MASK_64) == `TCP_PRE_MASK_64;
      `TCP_CS_DIV256: tick = (pre_q & `TCP_PRE_MASK_256) == `TCP_PRE_MASK_256;
      `TCP_CS_DIV1024: tick = (pre_q & `TCP_PRE_MASK_1024) == `TCP_PRE_MASK_1024;
      `TCP_CS_EXT_FALL: tick = ext_s3_q && !ext_s2_q;
      default: tick = !ext_s3_q && ext_s2_q;
    endcase
  end

  // ----------------------------------------------------------------
  // Counter and compare
  // ----------------------------------------------------------------
  assign cnt_top = (wgm == `TCP_WGM_CTC || wgm == `TCP_WGM_FAST_OCR) ? i_cmp_a
                                                                      : `TCP_CNT_MAX;
  assign match_a = tick && (cnt_q == i_cmp_a);
  assign bottom = tick && (cnt_q == cnt_top);

  // A force strobe never touches the counter.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q <= `TCP_CNT_BOTTOM;
    end else if (bottom) begin
      cnt_q <= `TCP_CNT_BOTTOM;
    end else if (tick) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      match_q <= 1'b0;
    end else begin
      match_q <= match_a;
    end
  end

  assign o_count = cnt_q;
  assign o_match_a = match_q;

  // ----------------------------------------------------------------
  // Waveform unit
  // ----------------------------------------------------------------
  assign wif.com = ctrl_a_q[`TCP_COM_A_HI:`TCP_COM_A_LO];
  assign wif.wgm2 = wgm[2];
  assign wif.match = match_a;
  assign wif.bottom = bottom;
  assign wif.force_a = wr_ctrl_b && i_wr_data[`TCP_FORCE_A]
                       && (wif.wave == tcp_pkg::TCP_WAVE_NONPWM);

  always_comb begin
    if (wgm[0] == 1'b0) begin
      wif.wave = tcp_pkg::TCP_WAVE_NONPWM;
    end else if (wgm[1]) begin
      wif.wave = tcp_pkg::TCP_WAVE_FAST;
    end else begin
      wif.wave = tcp_pkg::TCP_WAVE_PHASE;
    end
  end

  tcp_wave_unit u_wave (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .w(wif.unit)
  );

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  assign override = (wif.com != 2'b00);

  always_comb begin
    pin_out_d = port_q;
    if (override) begin
      pin_out_d[CMP_PIN] = wif.oc;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_out_q <= '0;
    end else begin
      pin_out_q <= pin_out_d;
    end
  end

  assign o_pin_b = pin_out_q;
  // The compare output never enables the driver by itself.
  assign o_pin_b_oe = dir_q;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    rd_d = 8'h00;
    if (data_addr == `TCP_OFS_PIN_B) begin
      rd_d = pin_s2_q;
    end else if (data_addr == `TCP_OFS_DIR_B) begin
      rd_d = dir_q;
    end else if (data_addr == `TCP_OFS_CTRL_A) begin
      rd_d = ctrl_a_q;
    end else if (data_addr == `TCP_OFS_CTRL_B) begin
      rd_d = ctrl_b_q;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_data <= 8'h00;
    end else if (i_rd) begin
      o_rd_data <= rd_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  sequence io_dir_wr_s;
    i_wr && i_io_space && (i_addr == 8'h04);
  endsequence

  sequence pin_wr_s;
    i_wr && !i_io_space && (i_addr == `TCP_OFS_PIN_B);
  endsequence

  io_alias_a: assert property (
    io_dir_wr_s |=> dir_q == $past(i_wr_data))
    else $error("I/O-space write missed the direction register.");
  pin_toggle_a: assert property (
    pin_wr_s |=> port_q == ($past(port_q) ^ $past(i_wr_data)))
    else $error("Pin register write did not toggle.");
  oe_follow_a: assert property (
    wr_dir |=> o_pin_b_oe == $past(i_wr_data))
    else $error("Driver enable ignores the direction bit.");
  cmp_override_a: assert property (
    override |=> o_pin_b[CMP_PIN] == $past(wif.oc))
    else $error("Compare output not on the pin.");
  port_normal_a: assert property (
    !override |=> o_pin_b == $past(port_q))
    else $error("Port value not on the pins.");
  ctrl_a_zero_a: assert property (
    i_rd && data_addr == `TCP_OFS_CTRL_A |=> o_rd_data[3:2] == 2'b00)
    else $error("Reserved control A bits read nonzero.");
  force_zero_a: assert property (
    i_rd && data_addr == `TCP_OFS_CTRL_B |=> o_rd_data[7:4] == 4'h0)
    else $error("Force strobes read nonzero.");
  stop_hold_a: assert property (
    cs == `TCP_CS_STOP && !wr_ctrl_b |=> cnt_q == $past(cnt_q))
    else $error("Counter moved while stopped.");
  match_flag_a: assert property (
    tick && cnt_q == i_cmp_a |=> o_match_a)
    else $error("Compare match not flagged.");

endmodule

`default_nettype wire

// *** src/tcp_defs.svh ***
`ifndef TCP_DEFS_SVH
`define TCP_DEFS_SVH

// ----------------------------------------------------------------
// Register map, data-space offsets
// ----------------------------------------------------------------
`define TCP_IO_BASE        8'h20
`define TCP_IO_ADDR_MASK   8'h3f
`define TCP_OFS_PIN_B      8'h23
`define TCP_OFS_DIR_B      8'h24
`define TCP_OFS_CTRL_A     8'h44
`define TCP_OFS_CTRL_B     8'h45

// ----------------------------------------------------------------
// Reset values and writable bits
// ----------------------------------------------------------------
`define TCP_RST_DIR_B      8'h00
`define TCP_RST_PORT_B     8'h00
`define TCP_RST_CTRL_A     8'h00
`define TCP_RST_CTRL_B     8'h00
`define TCP_CTRL_A_MASK    8'hf3
`define TCP_CTRL_B_MASK    8'h0f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TCP_COM_A_HI       7
`define TCP_COM_A_LO       6
`define TCP_COM_B_HI       5
`define TCP_COM_B_LO       4
`define TCP_WGM_HI         1
`define TCP_WGM_LO         0
`define TCP_FORCE_A        7
`define TCP_FORCE_B        6
`define TCP_WGM_2          3
`define TCP_CS_HI          2
`define TCP_CS_LO          0

// ----------------------------------------------------------------
// Clock select codes, prescaler masks and counter limits
// ----------------------------------------------------------------
`define TCP_CS_STOP        3'h0
`define TCP_CS_DIV1        3'h1
`define TCP_CS_DIV8        3'h2
`define TCP_CS_DIV64       3'h3
`define TCP_CS_DIV256      3'h4
`define TCP_CS_DIV1024     3'h5
`define TCP_CS_EXT_FALL    3'h6
`define TCP_CS_EXT_RISE    3'h7
`define TCP_PRE_MASK_8     10'h007
`define TCP_PRE_MASK_64    10'h03f
`define TCP_PRE_MASK_256   10'h0ff
`define TCP_PRE_MASK_1024  10'h3ff
`define TCP_CNT_MAX        8'hff
`define TCP_CNT_BOTTOM     8'h00
`define TCP_WGM_CTC        3'h2
`define TCP_WGM_FAST_OCR   3'h7

`endif

// *** src/tcp_pkg.sv ***
`default_nettype none

package tcp_pkg;

  // Waveform families that change how the compare output reacts.
  typedef enum logic [1:0] {
    TCP_WAVE_NONPWM,
    TCP_WAVE_FAST,
    TCP_WAVE_PHASE
  } tcp_wave_t;

  typedef logic [1:0] tcp_com_t;

endpackage

`default_nettype wire

// *** src/tcp_wave_if.sv ***
`default_nettype none

interface tcp_wave_if;
  tcp_pkg::tcp_com_t com;
  tcp_pkg::tcp_wave_t wave;
  logic wgm2;
  logic match;
  logic bottom;
  logic force_a;
  logic oc;

  modport ctrl (output com, output wave, output wgm2, output match,
                output bottom, output force_a, input oc);
  modport unit (input com, input wave, input wgm2, input match,
                input bottom, input force_a, output oc);
endinterface

`default_nettype wire

// *** src/tcp_wave_unit.sv ***
`default_nettype none

module tcp_wave_unit (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Waveform controls
  tcp_wave_if.unit w
);

  logic oc_q;
  logic oc_d;
  logic nonpwm;
  logic fast;
  logic hit;

  assign nonpwm = (w.wave == tcp_pkg::TCP_WAVE_NONPWM);
  assign fast = (w.wave == tcp_pkg::TCP_WAVE_FAST);
  // A forced match only counts outside the PWM modes.
  assign hit = w.match | w.force_a;

  // ----------------------------------------------------------------
  // Compare output state
  // ----------------------------------------------------------------
  // Match is applied after bottom, so a match at bottom wins.
  always_comb begin
    oc_d = oc_q;
    case (w.com)
      2'b01: begin
        if (nonpwm && hit) begin
          oc_d = ~oc_q;
        end else if (fast && w.wgm2 && w.match) begin
          oc_d = ~oc_q;
        end
      end
      2'b10: begin
        if (fast) begin
          if (w.bottom) oc_d = 1'b1;
          if (w.match) oc_d = 1'b0;
        end else if (nonpwm && hit) begin
          oc_d = 1'b0;
        end
      end
      2'b11: begin
        if (fast) begin
          if (w.bottom) oc_d = 1'b0;
          if (w.match) oc_d = 1'b1;
        end else if (nonpwm && hit) begin
          oc_d = 1'b1;
        end
      end
      default: oc_d = oc_q;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      oc_q <= 1'b0;
    end else begin
      oc_q <= oc_d;
    end
  end

  assign w.oc = oc_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  nonpwm_toggle_a: assert property (
    nonpwm && w.com == 2'b01 && hit |=> oc_q != $past(oc_q))
    else $error("Toggle on match missed.");
  fast_disc_a: assert property (
    fast && w.com == 2'b01 && !w.wgm2 |=> oc_q == $past(oc_q))
    else $error("Fast mode code one changed the output.");
  fast_noninv_a: assert property (
    fast && w.com == 2'b10 && (w.match || w.bottom) |=> oc_q == !$past(w.match))
    else $error("Non-inverting output wrong.");
  fast_inv_a: assert property (
    fast && w.com == 2'b11 && (w.match || w.bottom) |=> oc_q == $past(w.match))
    else $error("Inverting output wrong.");

endmodule

`default_nettype wire

// *** tb/tcp_pin_env.sv ***
`default_nettype none

module tcp_pin_env (
  // Design side of the pins
  input wire logic [7:0] i_pin_out,
  input wire logic [7:0] i_pin_oe,
  // External drivers set by the bench
  input wire logic [7:0] i_ext_val,
  input wire logic [7:0] i_ext_drv,
  // Resolved pin levels
  output logic [7:0] o_pin_lvl
);
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------
  // Wire resolution
  // ------------------------------------------------------------
  // Undriven pins sit on pull-ups, so a released pin reads high unless the bench drives it.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      o_pin_lvl[i] = i_pin_oe[i] ? i_pin_out[i] : (i_ext_drv[i] ? i_ext_val[i] : 1'b1);
    end
  end
endmodule

`default_nettype wire

// *** tb/timer0_compare_output_port_b_bench.sv ***
`default_nettype none

module timer0_compare_output_port_b_bench;
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------
  // Design, pin environment and clock
  // ------------------------------------------------------------
  logic i_sys_clk, i_sys_rst, io, wr, rd, ext_clk, match;
  logic [7:0] addr, wdata, rdata, cmp, pin_in, pin_out, pin_oe, count, ext_val, ext_drv;
  int num_errors = 0;
  int total_checks = 0;

  tcp_timer0_cmp_portb u_dut (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(addr), .i_io_space(io),
    .i_wr(wr), .i_rd(rd), .i_wr_data(wdata), .o_rd_data(rdata), .i_cmp_a(cmp),
    .i_ext_clk(ext_clk), .i_pin_b(pin_in), .o_pin_b(pin_out), .o_pin_b_oe(pin_oe),
    .o_count(count), .o_match_a(match)
  );

  tcp_pin_env u_env (
    .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_ext_val(ext_val), .i_ext_drv(ext_drv),
    .o_pin_lvl(pin_in)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // ------------------------------------------------------------
  // Compare and bus tasks
  // ------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %b want %b", $time, what, got, exp);
    end
  endtask

  // Entered and left at a falling edge, so strobes last exactly one rising edge.
  // An idle edge follows, so a strobe is never lowered and raised in one step.
  task automatic wr_reg(input logic [7:0] a, input logic sp, input logic [7:0] d);
    addr = a;
    io = sp;
    wdata = d;
    wr = 1'b1;
    @(negedge i_sys_clk);
    wr = 1'b0;
    @(negedge i_sys_clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic sp, input logic [7:0] exp);
    addr = a;
    io = sp;
    rd = 1'b1;
    @(negedge i_sys_clk);
    rd = 1'b0;
    chk_byte(rdata, exp, "register read");
    @(negedge i_sys_clk);
  endtask

  task automatic wait_on(input logic m, input logic [7:0] v);
    int n;
    n = 0;
    while ((m ? match : (count == v)) !== 1'b1 && n < 600) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk_bit(n < 600, 1'b1, "event wait");
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk_byte(pin_oe, 8'h00, "enables at reset");
    rd_chk(8'h24, 1'b0, 8'h00);
    rd_chk(8'h44, 1'b0, 8'h00);
    rd_chk(8'h45, 1'b0, 8'h00);
  endtask

  task automatic t_map();
    wr_reg(8'h24, 1'b0, 8'h5a);
    rd_chk(8'h04, 1'b1, 8'h5a);
    chk_byte(pin_oe, 8'h5a, "driver enables");
    wr_reg(8'h24, 1'b1, 8'hff);
    rd_chk(8'h44, 1'b0, 8'hf3);
    wr_reg(8'h25, 1'b1, 8'hc8);
    rd_chk(8'h45, 1'b0, 8'h08);
    rd_chk(8'h25, 1'b1, 8'h08);
    wr_reg(8'h30, 1'b0, 8'hff);
    rd_chk(8'h30, 1'b0, 8'h00);
    wr_reg(8'h44, 1'b0, 8'h00);
    wr_reg(8'h45, 1'b0, 8'h00);
    wr_reg(8'h24, 1'b0, 8'h00);
  endtask

  task automatic t_toggle();
    wr_reg(8'h24, 1'b0, 8'hff);
    wr_reg(8'h23, 1'b0, 8'h81);
    @(negedge i_sys_clk);
    chk_byte(pin_out, 8'h81, "pin toggle");
    wr_reg(8'h03, 1'b1, 8'h01);
    repeat (3) @(negedge i_sys_clk);
    chk_byte(pin_out, 8'h80, "pin toggle back");
    rd_chk(8'h23, 1'b0, 8'h80);
    wr_reg(8'h24, 1'b0, 8'h00);
    ext_val = 8'ha5;
    ext_drv = 8'hff;
    repeat (4) @(negedge i_sys_clk);
    rd_chk(8'h03, 1'b1, 8'ha5);
    ext_drv = 8'h00;
  endtask

  task automatic t_force();
    logic [7:0] c0;
    logic [7:0] cv = 8'b01_01_10_11;
    logic [3:0] expv = 4'b0101;
    wr_reg(8'h24, 1'b0, 8'h40);
    wr_reg(8'h44, 1'b0, 8'hc0);
    wr_reg(8'h23, 1'b0, 8'h40);
    c0 = count;
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h44, 1'b0, {cv[2*i+:2], 6'h00});
      wr_reg(8'h45, 1'b0, 8'h80);
      chk_bit(match, 1'b0, "no match event");
      @(negedge i_sys_clk);
      chk_bit(pin_out[6], expv[i], "forced output");
    end
    chk_byte(count, c0, "counter kept");
    chk_bit(pin_out[6], 1'b0, "override hides latch");
    wr_reg(8'h44, 1'b0, 8'h00);
    @(negedge i_sys_clk);
    chk_bit(pin_out[6], 1'b1, "port drives pin");
    wr_reg(8'h24, 1'b0, 8'h00);
    wr_reg(8'h44, 1'b0, 8'hc0);
    chk_byte(pin_oe, 8'h00, "no driver without direction");
  endtask

  task automatic t_clock();
    int divs [6] = '{16, 1, 8, 64, 256, 1024};
    logic [7:0] c0;
    for (int s = 0; s < 8; s++) begin
      wr_reg(8'h45, 1'b0, 8'(s));
      repeat (4) @(negedge i_sys_clk);
      c0 = count;
      if (s < 6) begin
        repeat (4 * divs[s]) @(negedge i_sys_clk);
      end else begin
        repeat (8) begin
          repeat (4) @(negedge i_sys_clk);
          ext_clk = ~ext_clk;
        end
        repeat (6) @(negedge i_sys_clk);
      end
      chk_byte(8'(count - c0), (s == 0) ? 8'h00 : 8'h04, "counter step");
    end
  endtask

  task automatic t_match();
    logic p;
    wr_reg(8'h24, 1'b0, 8'h40);
    wr_reg(8'h44, 1'b0, 8'h40);
    cmp = 8'h05;
    wr_reg(8'h45, 1'b0, 8'h01);
    wait_on(1'b1, 8'h00);
    p = pin_out[6];
    chk_byte(count, 8'h06, "count after match");
    @(negedge i_sys_clk);
    chk_bit(match, 1'b0, "match pulse width");
    chk_bit(pin_out[6], ~p, "toggle on match");
  endtask

  // Cases: clear on match, set on match, code 01 holding, code 01 toggling.
  task automatic t_fast();
    logic a, b, c;
    logic [7:0] ca [4] = '{8'h83, 8'hc3, 8'h43, 8'h43};
    logic [7:0] cb [4] = '{8'h01, 8'h01, 8'h01, 8'h09};
    logic [3:0] ea = 4'b0110;
    logic [3:0] eb = 4'b0101;
    cmp = 8'h80;
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h44, 1'b0, ca[i]);
      wr_reg(8'h45, 1'b0, cb[i]);
      wait_on(1'b1, 8'h00);
      @(negedge i_sys_clk);
      a = pin_out[6];
      wait_on(1'b0, 8'h10);
      b = pin_out[6];
      wait_on(1'b1, 8'h00);
      @(negedge i_sys_clk);
      c = pin_out[6];
      if (i < 3) begin
        chk_bit(a, ea[i], "after match");
        chk_bit(b, eb[i], "after bottom");
        chk_bit(c, ea[i], "next match");
      end else begin
        chk_bit(b, a, "no change at bottom");
        chk_bit(c, ~a, "toggle each match");
      end
    end
  endtask

  // Clear-on-match mode wraps at the compare value; a phase mode ignores a force.
  task automatic t_modes();
    logic p;
    cmp = 8'h09;
    wr_reg(8'h45, 1'b0, 8'h01);
    wr_reg(8'h44, 1'b0, 8'h42);
    wait_on(1'b1, 8'h00);
    chk_byte(count, 8'h00, "wrap at compare");
    @(negedge i_sys_clk);
    p = pin_out[6];
    wait_on(1'b1, 8'h00);
    @(negedge i_sys_clk);
    chk_bit(pin_out[6], ~p, "toggle in clear-on-match mode");
    wr_reg(8'h45, 1'b0, 8'h00);
    wr_reg(8'h44, 1'b0, 8'h41);
    p = pin_out[6];
    wr_reg(8'h45, 1'b0, 8'h80);
    @(negedge i_sys_clk);
    chk_bit(pin_out[6], p, "force ignored in phase mode");
  endtask

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // The whole sequence needs about 8000 cycles; this leaves ample margin.
  initial begin
    repeat (40000) @(posedge i_sys_clk);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    i_sys_rst = 1'b1;
    io = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    ext_clk = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    cmp = 8'h00;
    ext_val = 8'h00;
    ext_drv = 8'h00;
    repeat (2) @(negedge i_sys_clk);
    i_sys_rst = 1'b0;
    @(negedge i_sys_clk);
    t_reset();
    $display("reset test done");
    t_map();
    $display("map test done");
    t_toggle();
    $display("toggle test done");
    t_force();
    $display("force test done");
    t_clock();
    $display("clock test done");
    t_match();
    $display("match test done");
    t_fast();
    $display("fast test done");
    t_modes();
    $display("modes test done");
    conclude();
  end
endmodule

`default_nettype wire
